// ==== hw/ccw_map.vh ====
// Register map, field positions, reset values and timing counts of the card command block
`ifndef CCW_MAP_VH
`define CCW_MAP_VH

`define CCW_OFF_CMD      8'h00
`define CCW_OFF_ARG      8'h04
`define CCW_OFF_BLEN     8'h08
`define CCW_OFF_NBLK     8'h0c
`define CCW_OFF_STAT     8'h10
`define CCW_OFF_MASK     8'h14
`define CCW_OFF_RSP      8'h18
`define CCW_OFF_RIDX     8'h1c
`define CCW_OFF_RXD      8'h20
`define CCW_OFF_TXD      8'h24

`define CCW_B_CLR        15
`define CCW_B_INIT       14
`define CCW_B_DATA       13
`define CCW_B_STRM       12
`define CCW_B_WR         11
`define CCW_B_FMT_HI     10
`define CCW_B_FMT_LO     9
`define CCW_B_BUSY       8
`define CCW_B_PP         7
`define CCW_B_IDX_HI     5

`define CCW_CMD_MASK     16'hffbf
`define CCW_RST_CMD      16'h0000
`define CCW_RST_ARG      32'h00000000
`define CCW_RST_BLEN     12'h200
`define CCW_RST_NBLK     16'h0000
`define CCW_RST_MASK     8'h00

`define CCW_FMT_NONE     2'h0
`define CCW_FMT_R1       2'h1
`define CCW_FMT_R2       2'h2
`define CCW_FMT_R3       2'h3

`define CCW_S_CMD        0
`define CCW_S_RSP        1
`define CCW_S_CRC        2
`define CCW_S_TMO        3
`define CCW_S_BUSY       4
`define CCW_S_DATA       5
`define CCW_S_RX         6
`define CCW_S_TX         7

`define CCW_INIT_CLKS    8'h50
`define CCW_FRAME_BITS   8'h30
`define CCW_LONG_BITS    8'h88
`define CCW_R2_CRC_TOP   8'h80
`define CCW_RSP_TIMEOUT  8'h40
`define CCW_BUSY_MIN     8'h02

`endif

// ==== hw/ccw_crc7.v ====
// Serial CRC7 generator, polynomial x^7 + x^3 + 1
`timescale 1ns/1ps
`default_nettype none
module ccw_crc7 (
  input  wire       clock_in,
  input  wire       rst_in,
  input  wire       clr_in,
  input  wire       en_in,
  input  wire       bit_in,
  output reg  [6:0] crc_out
);
  wire fb = bit_in ^ crc_out[6];

  always @(posedge clock_in) begin
    if (rst_in || clr_in) begin
      crc_out <= 7'h00;
    end else if (en_in) begin
      crc_out <= {crc_out[5:3], crc_out[2] ^ fb, crc_out[1:0], fb};
    end
  end
endmodule
`default_nettype wire

// ==== hw/ccw_card_command_word_control.v ====
// Command-word register, APB slave and command, response, busy and data sequencer
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ccw_map.vh"
module ccw_card_command_word_control #(
  parameter [7:0] RSP_TIMEOUT = `CCW_RSP_TIMEOUT
) (
  input  wire        clock_in,
  input  wire        rst_in,
  input  wire [7:0]  paddr_in,
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [31:0] pwdata_in,
  output reg  [31:0] prdata_out,
  output wire        pready_out,
  output reg         pslverr_out,
  input  wire        card_clk_in,
  input  wire        cmd_in,
  output reg         cmd_out,
  output reg         cmd_oe_out,
  input  wire        dat_in,
  output reg         dat_out,
  output reg         dat_oe_out,
  output wire        irq_out
);
  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_INIT = 7'h02;
  localparam [6:0] ST_CMD  = 7'h04;
  localparam [6:0] ST_RSPW = 7'h08;
  localparam [6:0] ST_RSP  = 7'h10;
  localparam [6:0] ST_BUSY = 7'h20;
  localparam [6:0] ST_DATA = 7'h40;

  reg  [15:0] cmd_word;
  reg  [31:0] arg;
  reg  [11:0] blen;
  reg  [15:0] nblk;
  reg  [7:0]  status;
  reg  [7:0]  mask;
  reg  [31:0] rsp_word;
  reg  [5:0]  rsp_idx;
  reg  [7:0]  rx_data;
  reg  [7:0]  tx_data;
  reg  [6:0]  state;
  reg  [15:0] cur;
  reg  [7:0]  n;
  reg  [7:0]  cnt;
  reg  [39:0] tx_frame;
  reg  [39:0] rx_sh;
  reg         crc_ok;
  reg  [2:0]  bitc;
  reg  [11:0] byte_cnt;
  reg  [15:0] blk_cnt;
  reg  [7:0]  rx_byte;
  reg  [7:0]  tx_sh;
  reg  [7:0]  ev;
  reg  [2:0]  sy1;
  reg  [2:0]  sy2;
  reg  [2:0]  sy3;
  reg  [2:0]  stab;
  wire [6:0]  tx_crc;
  wire [6:0]  rx_crc;
  wire [2:0]  agree = ~(sy2 ^ sy3);
  wire [2:0]  nstab = (agree & sy3) | (~agree & stab);

  // Three-stage synchronisers for card clock, command and data lines
  always @(posedge clock_in) begin
    if (rst_in) begin
      sy1  <= 3'h7;
      sy2  <= 3'h7;
      sy3  <= 3'h7;
      stab <= 3'h7;
    end else begin
      sy1  <= {dat_in, cmd_in, card_clk_in};
      sy2  <= sy1;
      sy3  <= sy2;
      stab <= nstab;
    end
  end

  wire       lrise = nstab[0] & ~stab[0];
  wire       lfall = ~nstab[0] & stab[0];
  wire       cmd_s = nstab[1];
  wire       dat_s = nstab[2];

  // Decode of the latched command word
  wire [1:0] fmt      = cur[`CCW_B_FMT_HI:`CCW_B_FMT_LO];
  wire [7:0] len      = (fmt == `CCW_FMT_R2) ? `CCW_LONG_BITS : `CCW_FRAME_BITS;
  wire [6:0] after_bsy = cur[`CCW_B_DATA] ? ST_DATA : ST_IDLE;
  wire [6:0] after_rsp = cur[`CCW_B_BUSY] ? ST_BUSY : after_bsy;
  wire [6:0] after_cmd = (fmt == `CCW_FMT_NONE) ? after_rsp : ST_RSPW;
  wire [2:0] crc_sel  = n[2:0] - 3'h2;
  wire       tx_bit   = (n >= 8'h09) ? tx_frame[39] : (n == 8'h01) ? 1'b1 : tx_crc[crc_sel];
  wire       rx_use   = (n >= 8'h09) && ((fmt != `CCW_FMT_R2) || (n <= `CCW_R2_CRC_TOP));
  wire       d_edge   = cur[`CCW_B_WR] ? lfall : lrise;

  // APB decode
  wire setup  = psel_in & ~penable_in;
  wire wr_acc = psel_in & penable_in & pwrite_in;
  wire wr_cmd = wr_acc & (paddr_in == `CCW_OFF_CMD);
  wire open_data = (state == ST_DATA) & (cur[`CCW_B_STRM] | (nblk == 16'h0000));
  wire start  = wr_cmd & ((state == ST_IDLE) | open_data);

  function mapped;
    input [7:0] a;
    begin
      mapped = (a[1:0] == 2'h0) && (a <= `CCW_OFF_TXD);
    end
  endfunction

  assign pready_out = 1'b1;
  assign irq_out    = |(status & mask);

  ccw_crc7 u_tx_crc (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .clr_in   (start),
    .en_in    ((state == ST_CMD) & lfall & (n >= 8'h09) & ~start),
    .bit_in   (tx_frame[39]),
    .crc_out  (tx_crc)
  );

  ccw_crc7 u_rx_crc (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .clr_in   ((state == ST_CMD) & lfall & (n == 8'h00)),
    .en_in    (lrise & ~start & (((state == ST_RSPW) & ~cmd_s) | ((state == ST_RSP) & rx_use))),
    .bit_in   (cmd_s),
    .crc_out  (rx_crc)
  );

  // Software registers
  always @(posedge clock_in) begin
    if (rst_in) begin
      cmd_word <= `CCW_RST_CMD;
      arg      <= `CCW_RST_ARG;
      blen     <= `CCW_RST_BLEN;
      nblk     <= `CCW_RST_NBLK;
      mask     <= `CCW_RST_MASK;
      tx_data  <= 8'h00;
    end else if (wr_acc) begin
      case (paddr_in)
        `CCW_OFF_CMD:  cmd_word <= pwdata_in[15:0] & `CCW_CMD_MASK;
        `CCW_OFF_ARG:  arg      <= pwdata_in;
        `CCW_OFF_BLEN: blen     <= pwdata_in[11:0];
        `CCW_OFF_NBLK: nblk     <= pwdata_in[15:0];
        `CCW_OFF_MASK: mask     <= pwdata_in[7:0];
        `CCW_OFF_TXD:  tx_data  <= pwdata_in[7:0];
        default: ;
      endcase
    end
  end

  // Sticky status, write one to clear, new event wins
  wire [7:0] clr_w1c = (wr_acc && (paddr_in == `CCW_OFF_STAT)) ? pwdata_in[7:0] : 8'h00;
  wire [7:0] clr_rdy = (wr_cmd && pwdata_in[`CCW_B_CLR]) ? 8'hc0 : 8'h00;

  always @(posedge clock_in) begin
    if (rst_in) begin
      status <= 8'h00;
    end else begin
      status <= (status & ~(clr_w1c | clr_rdy)) | ev;
    end
  end

  // Read data and error captured in the setup cycle
  always @(posedge clock_in) begin
    if (rst_in) begin
      prdata_out  <= 32'h00000000;
      pslverr_out <= 1'b0;
    end else if (setup) begin
      pslverr_out <= ~mapped(paddr_in);
      case (paddr_in)
        `CCW_OFF_CMD:  prdata_out <= {16'h0000, cmd_word};
        `CCW_OFF_ARG:  prdata_out <= arg;
        `CCW_OFF_BLEN: prdata_out <= {20'h00000, blen};
        `CCW_OFF_NBLK: prdata_out <= {16'h0000, nblk};
        `CCW_OFF_STAT: prdata_out <= {24'h000000, status};
        `CCW_OFF_MASK: prdata_out <= {24'h000000, mask};
        `CCW_OFF_RSP:  prdata_out <= rsp_word;
        `CCW_OFF_RIDX: prdata_out <= {9'h000, state, blk_cnt} | {26'h0000000, rsp_idx};
        `CCW_OFF_RXD:  prdata_out <= {24'h000000, rx_data};
        `CCW_OFF_TXD:  prdata_out <= {24'h000000, tx_data};
        default:       prdata_out <= 32'h00000000;
      endcase
    end
  end

  // Sequencer
  always @(posedge clock_in) begin
    if (rst_in) begin
      state      <= ST_IDLE;
      cur        <= `CCW_RST_CMD;
      n          <= 8'h00;
      cnt        <= 8'h00;
      tx_frame   <= 40'h0000000000;
      rx_sh      <= 40'h0000000000;
      crc_ok     <= 1'b1;
      cmd_out    <= 1'b1;
      cmd_oe_out <= 1'b0;
      dat_out    <= 1'b1;
      dat_oe_out <= 1'b0;
      bitc       <= 3'h0;
      byte_cnt   <= 12'h000;
      blk_cnt    <= 16'h0000;
      rx_byte    <= 8'h00;
      tx_sh      <= 8'h00;
      rx_data    <= 8'h00;
      rsp_word   <= 32'h00000000;
      rsp_idx    <= 6'h00;
      ev         <= 8'h00;
    end else begin
      ev <= 8'h00;
      if (start) begin
        cur        <= pwdata_in[15:0] & `CCW_CMD_MASK;
        tx_frame   <= {2'b01, pwdata_in[`CCW_B_IDX_HI:0], arg};
        n          <= `CCW_FRAME_BITS;
        cnt        <= 8'h00;
        bitc       <= 3'h0;
        byte_cnt   <= 12'h000;
        blk_cnt    <= 16'h0000;
        dat_oe_out <= 1'b0;
        cmd_out    <= 1'b1;
        cmd_oe_out <= pwdata_in[`CCW_B_PP];
        ev[`CCW_S_DATA] <= (state == ST_DATA);
        state      <= pwdata_in[`CCW_B_INIT] ? ST_INIT : ST_CMD;
      end else begin
        case (state)
          ST_IDLE: begin
            if (lfall) begin
              dat_oe_out <= 1'b0;
            end
          end
          ST_INIT: begin
            if (lrise) begin
              if (cnt == `CCW_INIT_CLKS - 8'h01) begin
                cnt   <= 8'h00;
                state <= ST_CMD;
              end else begin
                cnt <= cnt + 8'h01;
              end
            end
          end
          ST_CMD: begin
            if (lfall) begin
              if (n == 8'h00) begin
                cmd_out    <= 1'b1;
                cmd_oe_out <= 1'b0;
                cnt        <= 8'h00;
                crc_ok     <= 1'b1;
                ev[`CCW_S_CMD] <= 1'b1;
                state      <= after_cmd;
              end else begin
                cmd_out    <= tx_bit;
                cmd_oe_out <= cur[`CCW_B_PP] | ~tx_bit;
                n          <= n - 8'h01;
                if (n >= 8'h09) begin
                  tx_frame <= {tx_frame[38:0], 1'b0};
                end
              end
            end
          end
          ST_RSPW: begin
            if (lrise) begin
              if (!cmd_s) begin
                n     <= len - 8'h01;
                rx_sh <= 40'h0000000000;
                state <= ST_RSP;
              end else if (cnt == RSP_TIMEOUT - 8'h01) begin
                ev[`CCW_S_TMO] <= 1'b1;
                state <= ST_IDLE;
              end else begin
                cnt <= cnt + 8'h01;
              end
            end
          end
          ST_RSP: begin
            if (lrise) begin
              rx_sh <= {rx_sh[38:0], cmd_s};
              if ((n >= 8'h02) && (n <= 8'h08) && (cmd_s != rx_crc[crc_sel])) begin
                crc_ok <= 1'b0;
              end
              if (n == len - 8'h07) begin
                rsp_idx <= {rx_sh[4:0], cmd_s};
              end
              if (n == 8'h01) begin
                rsp_word <= rx_sh[38:7];
                ev[`CCW_S_RSP] <= 1'b1;
                ev[`CCW_S_CRC] <= ~crc_ok & (fmt != `CCW_FMT_R3);
                cnt   <= 8'h00;
                state <= after_rsp;
              end else begin
                n <= n - 8'h01;
              end
            end
          end
          ST_BUSY: begin
            if (lrise) begin
              if ((cnt >= `CCW_BUSY_MIN) && dat_s) begin
                ev[`CCW_S_BUSY] <= 1'b1;
                state <= after_bsy;
              end else if (cnt != 8'hff) begin
                cnt <= cnt + 8'h01;
              end
            end
          end
          ST_DATA: begin
            if (d_edge) begin
              bitc <= bitc + 3'h1;
              if (cur[`CCW_B_WR]) begin
                dat_oe_out <= 1'b1;
                if (bitc == 3'h0) begin
                  dat_out <= tx_data[7];
                  tx_sh   <= {tx_data[6:0], 1'b0};
                  ev[`CCW_S_TX] <= 1'b1;
                end else begin
                  dat_out <= tx_sh[7];
                  tx_sh   <= {tx_sh[6:0], 1'b0};
                end
              end else begin
                rx_byte <= {rx_byte[6:0], dat_s};
              end
              if (bitc == 3'h7) begin
                if (!cur[`CCW_B_WR]) begin
                  rx_data <= {rx_byte[6:0], dat_s};
                  ev[`CCW_S_RX] <= 1'b1;
                end
                if (!cur[`CCW_B_STRM]) begin
                  if (byte_cnt == blen - 12'h001) begin
                    byte_cnt <= 12'h000;
                    blk_cnt  <= blk_cnt + 16'h0001;
                    if ((nblk != 16'h0000) && (blk_cnt == nblk - 16'h0001)) begin
                      ev[`CCW_S_DATA] <= 1'b1;
                      state <= ST_IDLE;
                    end
                  end else begin
                    byte_cnt <= byte_cnt + 12'h001;
                  end
                end
              end
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/ccw_checker.sv ====
// Port assertions of the card command block
`timescale 1ns/1ps
`default_nettype none
module ccw_checker (
  input wire logic        clock_in,
  input wire logic        rst_in,
  input wire logic [7:0]  paddr_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [31:0] pwdata_in,
  input wire logic        pslverr_out,
  input wire logic        cmd_out,
  input wire logic        cmd_oe_out,
  input wire logic        dat_oe_out,
  input wire logic        irq_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  logic [15:0] cw;
  logic [1:0]  age;
  logic [10:0] icnt;
  logic        ipend;
  wire         apb_wr = psel_in && penable_in && pwrite_in;
  wire         cw_wr = apb_wr && paddr_in == 8'h00;
  wire         start = cmd_oe_out && !cmd_out;
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cw <= 16'h0000;
      age <= 2'h3;
      ipend <= 1'b0;
    end else begin
      if (cw_wr) cw <= pwdata_in[15:0];
      age <= cw_wr ? 2'h0 : age + {1'b0, age != 2'h3};
      ipend <= cw_wr ? pwdata_in[14] : ipend && !start;
    end
  end
  // Cycles since the last command word write
  always_ff @(posedge clock_in) icnt <= cw_wr ? 11'h000 : icnt + 11'h001;
  od_drive_a: assert property (!cw[7] && cmd_oe_out |-> !cmd_out)
    else $error("open drain line driven high");
  pp_hold_a: assert property (cw[7] && $rose(cmd_oe_out) |=> cmd_oe_out [*8])
    else $error("push pull drive dropped");
  init_idle_a: assert property (cw_wr && pwdata_in[14] |=> (cmd_out || !cmd_oe_out) [*8])
    else $error("line not idle during init clocks");
  cmd_start_a: assert property (cw_wr && !pwdata_in[14] |-> ##[1:40] start)
    else $error("command did not start");
  init_len_a: assert property (ipend && start |-> icnt >= 11'h274 && icnt <= 11'h294)
    else $error("init clock count wrong");
  no_drive_a: assert property (age == 2'h3 && !(cw[13] && cw[11]) |-> !dat_oe_out)
    else $error("data line driven without write phase");
  slv_err_a: assert property (psel_in && !penable_in && paddr_in > 8'h24 |=> pslverr_out)
    else $error("unmapped access not flagged");
  irq_mask_a: assert property (apb_wr && paddr_in == 8'h14 && pwdata_in[7:0] == 8'h00 |=> !irq_out)
    else $error("masked interrupt still high");
  cover property (cw_wr && pwdata_in[14]);
  cover property ($rose(dat_oe_out));
  cover property ($rose(irq_out));
endmodule
bind ccw_card_command_word_control ccw_checker i_chk (.clock_in(clock_in), .rst_in(rst_in),
  .paddr_in(paddr_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
  .pwdata_in(pwdata_in), .pslverr_out(pslverr_out), .cmd_out(cmd_out), .cmd_oe_out(cmd_oe_out),
  .dat_oe_out(dat_oe_out), .irq_out(irq_out));
`default_nettype wire

// ==== tb/ccw_card_model.sv ====
// Behavioural memory card on the command and data lines
`timescale 1ns/1ps
`default_nettype none
module ccw_card_model (
  input  wire logic        run_in,
  input  wire logic        cmd_in,
  input  wire logic [7:0]  rsp_len_in,
  input  wire logic [3:0]  busy_len_in,
  output var logic         clk_out,
  output var logic         cmd_oe_out,
  output var logic         cmd_bit_out,
  output var logic         dat_oe_out,
  output var logic [47:0]  frame_out
);
  localparam logic [135:0] RSP = {2'b00, 6'h3f, 88'h0, 32'hc0de1234, 8'h01};
  logic [47:0] sh = 48'h0;
  logic [7:0]  n = 8'h00;
  int          tx = 0;
  int          bz = 0;
  initial begin
    clk_out = 1'b1;
    cmd_oe_out = 1'b0;
    cmd_bit_out = 1'b1;
    dat_oe_out = 1'b0;
    frame_out = 48'h0;
  end
  // Clock stands still while not running
  always #200 if (run_in) clk_out = ~clk_out;
  // Host bits are sampled on the falling edge one period after the one that launches them
  always @(negedge clk_out) begin
    if (tx == 0 && !cmd_oe_out && (n != 8'h00 || !cmd_in)) begin
      sh = {sh[46:0], cmd_in};
      n = n + 8'h01;
    end
    if (n == 8'h30) begin
      frame_out = sh;
      n = 8'h00;
      tx = rsp_len_in + 1;
    end
    cmd_oe_out = tx > 0 && tx <= rsp_len_in;
    if (cmd_oe_out) cmd_bit_out = RSP[tx-1];
    dat_oe_out = bz > 0;
    if (bz > 0) bz--;
    if (tx == 1) bz = busy_len_in;
    if (tx > 0) tx--;
  end
endmodule
`default_nettype wire

// ==== tb/ccw_card_command_word_control_test.sv ====
// Testbench of the card command block
`timescale 1ns/1ps
`default_nettype none
module ccw_card_command_word_control_test;
  logic        clock_in = 0, rst_in = 1, psel = 0, penable = 0, pwrite = 0, run = 0;
  logic [7:0]  paddr = 0, rsp_len = 0;
  logic [3:0]  busy_len = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic        pready, pslverr, card_clk, cmd_o, cmd_oe, dat_o, dat_oe, irq, c_oe, c_bit, d_oe;
  logic [47:0] frame;
  logic [7:0]  wbyte = 0;
  int          error_cnt = 0, checks_done = 0, cyc = 0, i, t;
  // Both lines carry pull-ups
  wire         cmd_w = cmd_oe ? cmd_o : c_oe ? c_bit : 1'b1;
  wire         dat_w = dat_oe ? dat_o : !d_oe;
  always #25 clock_in = ~clock_in;
  always @(posedge clock_in) cyc <= cyc + 1;
  // Card side takes written data bits on rising card clock edges
  always @(posedge card_clk) if (dat_oe) wbyte <= {wbyte[6:0], dat_w};
  ccw_card_command_word_control #(.RSP_TIMEOUT(8'h08)) i_dut (.clock_in(clock_in), .rst_in(rst_in),
    .paddr_in(paddr), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .card_clk_in(card_clk),
    .cmd_in(cmd_w), .cmd_out(cmd_o), .cmd_oe_out(cmd_oe), .dat_in(dat_w), .dat_out(dat_o),
    .dat_oe_out(dat_oe), .irq_out(irq));
  ccw_card_model i_card (.run_in(run), .cmd_in(cmd_w), .rsp_len_in(rsp_len), .busy_len_in(busy_len),
    .clk_out(card_clk), .cmd_oe_out(c_oe), .cmd_bit_out(c_bit), .dat_oe_out(d_oe), .frame_out(frame));
  task automatic final_report;
    if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    penable <= 1;
    @(posedge clock_in);
    while (pready !== 1'b1) @(posedge clock_in);
    r = prdata;
    psel <= 0;
    penable <= 0;
    @(posedge clock_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    xfer(0, a, 0);
    chk(r, exp);
  endtask
  task automatic wait_st(input int b);
    logic seen;
    seen = 1'b0;
    for (int k = 0; k < 2000 && !seen; k++) begin
      xfer(0, 8'h10, 0);
      seen = (r[b] === 1'b1);
    end
    if (!seen) begin
      error_cnt++;
      $display("BAD %0t status bit %0d never set", $time, b);
    end
  endtask
  initial begin
    #4000000;
    error_cnt++;
    final_report();
  end
  initial begin
    repeat (8) @(posedge clock_in);
    rst_in <= 0;
    @(posedge clock_in);
    rc(8'h00, 32'h0);
    xfer(0, 8'h28, 0);
    chk(pslverr, 1'b1);
    wr(8'h14, 32'hff);
    wr(8'h04, 32'h12345678);
    run <= 1;
    for (i = 0; i < 4; i++) begin
      rsp_len <= i == 0 ? 0 : i == 2 ? 136 : 48;
      busy_len <= i == 1 ? 6 : 0;
      wr(8'h00, i << 9 | (i == 1) << 8 | (i & 1) << 7 | i * 21);
      wait_st(0);
      chk(frame[47:40], 8'h40 | i * 21);
      chk(frame[39:8], 32'h12345678);
      if (i == 0) begin
        repeat (160) @(posedge clock_in);
        rc(8'h10, 32'h1);
      end else begin
        wait_st(1);
        rc(8'h10, i == 3 ? 32'h3 : 32'h7);
        rc(8'h18, 32'hc0de1234);
        if (i == 2) rc(8'h1c, 32'h0001003f);
        if (i == 1) begin
          wait_st(4);
          rc(8'h10, 32'h17);
        end
      end
      chk(irq, 1'b1);
      if (i == 3) wr(8'h14, 32'h0);
      if (i == 3) wr(8'h14, 32'hff);
      wr(8'h10, 32'hff);
      rc(8'h10, 32'h0);
    end
    rsp_len <= 0;
    t = cyc;
    wr(8'h00, 32'h4085);
    wait_st(0);
    chk(cyc - t > 1010 && cyc - t < 1070, 1'b1);
    rsp_len <= 48;
    wr(8'h08, 32'h2);
    wr(8'h0c, 32'h2);
    wr(8'h00, 32'h2601);
    wait_st(1);
    t = cyc;
    wait_st(5);
    chk(cyc - t > 240 && cyc - t < 290, 1'b1);
    rc(8'h10, 32'h63);
    rc(8'h20, 32'hff);
    wr(8'h10, 32'h3f);
    wr(8'h24, 32'ha5);
    wr(8'h00, 32'h2e02);
    wait_st(5);
    rc(8'h10, 32'he3);
    chk(wbyte, 8'ha5);
    wr(8'h10, 32'h3f);
    wr(8'h00, 32'h8603);
    wait_st(1);
    rc(8'h10, 32'h3);
    wr(8'h00, 32'h3604);
    wait_st(6);
    repeat (600) @(posedge clock_in);
    rc(8'h10, 32'h43);
    wr(8'h10, 32'h3);
    wr(8'h00, 32'h0605);
    wait_st(1);
    rc(8'h10, 32'h63);
    chk(frame[45:40], 6'h05);
    run <= 0;
    final_report();
  end
endmodule
`default_nettype wire
